//--- shpfc_pkg.sv
// package of constants for the serial host port with flow control
package shpfc_pkg;
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] SHPFC_CTRL_OFF   = 8'h00;
  localparam logic [7:0] SHPFC_STAT_OFF   = 8'h04;
  localparam logic [7:0] SHPFC_RXDATA_OFF = 8'h08;
  localparam logic [7:0] SHPFC_TXDATA_OFF = 8'h0C;
  localparam logic [7:0] SHPFC_NFULL_OFF  = 8'h10;
  // control field positions
  localparam int SHPFC_CTRL_BAUD_POS = 0;  // 2 bits
  localparam int SHPFC_CTRL_PAR_POS  = 2;  // 2 bits
  localparam int SHPFC_CTRL_ONL_POS  = 4;
  localparam int SHPFC_CTRL_SJOB_POS = 5;
  localparam int SHPFC_CTRL_PRT_POS  = 6;
  localparam int SHPFC_CTRL_FLT_POS  = 7;
  localparam logic [7:0] SHPFC_CTRL_RST = 8'h00;
  localparam logic [5:0] SHPFC_NFULL_RST = 6'h1C;
  // status field positions
  localparam int SHPFC_ST_RXERR_POS = 8;
  localparam int SHPFC_ST_TXBUSY_POS = 9;
  localparam int SHPFC_ST_HEADLATCH_POS = 10;
  localparam int SHPFC_ST_CTL_POS = 11;
  localparam int SHPFC_ST_COUNT_POS = 16;
  // control characters
  localparam logic [7:0] SHPFC_CH_STX = 8'h02;
  localparam logic [7:0] SHPFC_CH_ETX = 8'h03;
  localparam logic [7:0] SHPFC_CH_ACK = 8'h06;
  localparam logic [7:0] SHPFC_CH_NAK = 8'h15;
  // timing
  localparam int SHPFC_CLK_HZ = 50_000_000;
  localparam int SHPFC_BAUD0 = 9600;
  localparam int SHPFC_BAUD1 = 19200;
  localparam int SHPFC_BAUD2 = 38400;
  localparam int SHPFC_BAUD3 = 57600;
  localparam logic [12:0] SHPFC_DIV0 = 13'(SHPFC_CLK_HZ / SHPFC_BAUD0);
  localparam logic [12:0] SHPFC_DIV1 = 13'(SHPFC_CLK_HZ / SHPFC_BAUD1);
  localparam logic [12:0] SHPFC_DIV2 = 13'(SHPFC_CLK_HZ / SHPFC_BAUD2);
  localparam logic [12:0] SHPFC_DIV3 = 13'(SHPFC_CLK_HZ / SHPFC_BAUD3);
  // parity modes
  typedef enum logic [1:0] {
    SHPFC_PAR_NONE = 2'h0,
    SHPFC_PAR_ODD  = 2'h1,
    SHPFC_PAR_EVEN = 2'h2
  } shpfc_par_type;
  typedef enum logic [2:0] {
    SHPFC_S_IDLE, SHPFC_S_START, SHPFC_S_DATA, SHPFC_S_PAR, SHPFC_S_STOP
  } shpfc_ser_type;
endpackage : shpfc_pkg

//--- shpfc_fifo.sv
// synchronous valid/ready fifo for received characters
`timescale 1ns/1ps
module shpfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready,
  // occupancy
  output logic [AW:0]           o_count
);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } shpfc_fifo_type;
  shpfc_fifo_type st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // handshakes derive from the occupancy count only
  assign o_in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st_reg.cnt != '0);
  assign o_out_data  = mem[st_reg.rd];
  assign o_count     = st_reg.cnt;
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  // pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) st_next.wr = st_reg.wr + 1'b1;
    if (pop) st_next.rd = st_reg.rd + 1'b1;
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) st_reg <= '0;
    else st_reg <= st_next;
  end

  // storage has no reset on purpose; valid masks stale words
  always_ff @(posedge i_sys_clk) begin
    if (push) mem[st_reg.wr] <= i_in_data;
  end
endmodule : shpfc_fifo

//--- shpfc_port.sv
// serial host port with ready/busy flow control and ahb-lite registers
// Functional notes
// RULE1: baud select picks 9600, 19200, 38400 or 57600 bit/s for both ends.
// RULE2: frames carry eight data bits, one stop bit, parity odd/even/none.
// RULE3: received 0x02 and 0x03 are flagged as text delimiters.
// RULE4: received 0x06 and 0x15 are flagged as acknowledge characters.
// RULE5: the transmit line sends flow-control or status characters to host.
// RULE6: the error line idles high and goes low on head open or print fault.
// RULE7: after head open the error line rises only when closed and on-line.
// RULE8: reception is refused while the clear-to-send input is low.
// RULE9: characters are accepted only while data-set-ready is high.
// RULE10: the host raises data-set-ready before sending any character.
// RULE11: an unused qualifier input is strapped high by the host side.
// RULE12: ready/busy is high when data can be taken, low when off-line.
// RULE13: ready/busy is low while printing in single-job buffering mode.
// RULE14: ready/busy is low once the buffer reaches its near-full level.
// RULE15: frames start with a low bit and send data least significant first.
// RULE16: a parity mismatch or missing stop bit is flagged as receive error.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module shpfc_port #(
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // serial pins
  input  wire logic        i_rx_data,
  output logic             o_tx_data,
  input  wire logic        i_clear_to_send,
  input  wire logic        i_data_set_ready,
  output logic             o_error_n,
  output logic             o_ready_busy,
  // printer mechanism status
  input  wire logic        i_head_open
);
  import shpfc_pkg::*;

  typedef struct packed {
    logic [1:0]    s_rx, s_cts, s_dsr, s_head; // two-flop synchronisers
    logic [7:0]    ctrl;
    logic [5:0]    nfull;
    logic          a_en, a_wr;
    logic [7:0]    a_addr;
    logic [31:0]   rdata;
    logic          head_latch;                 // head was opened
    logic          rx_err, rx_ctl, rx_ack;
    shpfc_ser_type rx_st;
    logic [12:0]   rx_cnt;
    logic [2:0]    rx_bit;
    logic [7:0]    rx_sh;
    logic          rx_par;
    logic          push;
    logic [7:0]    push_data;
    shpfc_ser_type tx_st;
    logic [12:0]   tx_cnt;
    logic [2:0]    tx_bit;
    logic [7:0]    tx_sh;
    logic          tx_line;
  } shpfc_state_type;
  shpfc_state_type st_reg, st_next;

  logic        f_in_ready, f_out_valid, f_pop;
  logic [7:0]  f_out_data;
  logic [5:0]  f_count;
  logic [12:0] div;
  logic        online, near_full, rx_ok, par_on, par_odd;
  logic        a_take, bit_tick, tx_tick;

  shpfc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(5)) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_sys_rst  (i_sys_rst),
    .i_in_valid (st_reg.push),
    .i_in_data  (st_reg.push_data),
    .o_in_ready (f_in_ready),
    .o_out_valid(f_out_valid),
    .o_out_data (f_out_data),
    .i_out_ready(f_pop),
    .o_count    (f_count)
  );

  // baud divider from the selected rate
  always_comb begin
    unique case (st_reg.ctrl[SHPFC_CTRL_BAUD_POS +: 2])
      2'h0: div = SHPFC_DIV0; // RULE1
      2'h1: div = SHPFC_DIV1;
      2'h2: div = SHPFC_DIV2;
      2'h3: div = SHPFC_DIV3;
    endcase
  end

  // flow-control terms
  assign online    = st_reg.ctrl[SHPFC_CTRL_ONL_POS];
  assign near_full = (f_count >= st_reg.nfull); // RULE14
  // ready only when on-line, not printing single-job and not near full
  assign o_ready_busy = online && !near_full // RULE12
    && !(st_reg.ctrl[SHPFC_CTRL_SJOB_POS]
         && st_reg.ctrl[SHPFC_CTRL_PRT_POS]); // RULE13
  // error line low for open head, latched open, or print fault
  assign o_error_n = !(st_reg.s_head[1] || st_reg.head_latch // RULE6
                       || st_reg.ctrl[SHPFC_CTRL_FLT_POS]);
  assign rx_ok   = st_reg.s_cts[1] && st_reg.s_dsr[1]; // RULE8 RULE9
  assign par_on  = st_reg.ctrl[SHPFC_CTRL_PAR_POS +: 2] != SHPFC_PAR_NONE;
  assign par_odd = st_reg.ctrl[SHPFC_CTRL_PAR_POS +: 2] == SHPFC_PAR_ODD;
  assign bit_tick = (st_reg.rx_cnt == '0);
  assign tx_tick  = (st_reg.tx_cnt == '0);
  // bus side outputs and the transmit line
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = st_reg.rdata;
  assign o_tx_data   = st_reg.tx_line;
  assign a_take = i_hsel && i_hready && i_htrans[1];
  // reading rx data in the data phase pops one character
  assign f_pop = st_reg.a_en && !st_reg.a_wr
                 && st_reg.a_addr == SHPFC_RXDATA_OFF && f_out_valid;

  // whole next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.s_rx   = {st_reg.s_rx[0], i_rx_data};
    st_next.s_cts  = {st_reg.s_cts[0], i_clear_to_send};
    st_next.s_dsr  = {st_reg.s_dsr[0], i_data_set_ready};
    st_next.s_head = {st_reg.s_head[0], i_head_open};
    st_next.push = 1'b0;
    // address phase capture, one-cycle zero-wait slave
    st_next.a_en   = a_take;
    st_next.a_wr   = i_hwrite;
    st_next.a_addr = i_haddr;
    // read data is prepared in the address phase
    if (a_take && !i_hwrite) begin
      unique case (i_haddr)
        SHPFC_CTRL_OFF:   st_next.rdata = {24'h000000, st_reg.ctrl};
        SHPFC_STAT_OFF:   st_next.rdata = {10'h000, f_count,
                            2'h0, st_reg.rx_ack, st_reg.rx_ctl,
                            st_reg.tx_st != SHPFC_S_IDLE, 1'b0,
                            st_reg.head_latch, st_reg.rx_err,
                            o_error_n, o_ready_busy, rx_ok,
                            f_in_ready, near_full, f_out_valid,
                            st_reg.s_head[1], 1'b0};
        SHPFC_RXDATA_OFF: st_next.rdata = {23'h000000, f_out_valid,
                                           f_out_data};
        SHPFC_NFULL_OFF:  st_next.rdata = {26'h0000000, st_reg.nfull};
        default:          st_next.rdata = 32'h00000000;
      endcase
    end
    // data phase writes; status write of one clears sticky bits
    if (st_reg.a_en && st_reg.a_wr) begin
      unique case (st_reg.a_addr)
        SHPFC_CTRL_OFF: st_next.ctrl = i_hwdata[7:0];
        SHPFC_NFULL_OFF: st_next.nfull = i_hwdata[5:0];
        SHPFC_STAT_OFF: begin
          if (i_hwdata[SHPFC_ST_RXERR_POS]) st_next.rx_err = 1'b0;
          if (i_hwdata[SHPFC_ST_CTL_POS]) begin
            st_next.rx_ctl = 1'b0;
            st_next.rx_ack = 1'b0;
          end
        end
        SHPFC_TXDATA_OFF: begin
          if (st_reg.tx_st == SHPFC_S_IDLE) begin // RULE5
            st_next.tx_sh  = i_hwdata[7:0];
            st_next.tx_st  = SHPFC_S_START;
            st_next.tx_cnt = div;
          end
        end
        default: ;
      endcase
    end
    // head latch: set on open, cleared only when closed and on-line
    if (st_reg.s_head[1]) st_next.head_latch = 1'b1;
    else if (online) st_next.head_latch = 1'b0; // RULE7
    // receiver
    // reload one short so that every bit lasts exactly div cycles
    st_next.rx_cnt = bit_tick ? div - 13'h0001 : st_reg.rx_cnt - 13'h0001;
    unique case (st_reg.rx_st)
      SHPFC_S_IDLE: begin
        if (!st_reg.s_rx[1] && rx_ok) begin // RULE15
          st_next.rx_st  = SHPFC_S_START;
          st_next.rx_cnt = {1'b0, div[12:1]};
        end
      end
      SHPFC_S_START: if (bit_tick) begin
        st_next.rx_st  = st_reg.s_rx[1] ? SHPFC_S_IDLE : SHPFC_S_DATA;
        st_next.rx_bit = 3'h0;
        st_next.rx_par = par_odd;
      end
      SHPFC_S_DATA: if (bit_tick) begin
        st_next.rx_sh  = {st_reg.s_rx[1], st_reg.rx_sh[7:1]}; // RULE15
        st_next.rx_par = st_reg.rx_par ^ st_reg.s_rx[1];
        st_next.rx_bit = st_reg.rx_bit + 3'h1;
        if (st_reg.rx_bit == 3'h7) // RULE2
          st_next.rx_st = par_on ? SHPFC_S_PAR : SHPFC_S_STOP;
      end
      SHPFC_S_PAR: if (bit_tick) begin
        if (st_reg.s_rx[1] != st_reg.rx_par) st_next.rx_err = 1'b1; // RULE16
        st_next.rx_st = SHPFC_S_STOP;
      end
      SHPFC_S_STOP: if (bit_tick) begin
        st_next.rx_st = SHPFC_S_IDLE;
        if (!st_reg.s_rx[1]) st_next.rx_err = 1'b1; // RULE16
        else begin
          st_next.push      = f_in_ready;
          st_next.push_data = st_reg.rx_sh;
          if (st_reg.rx_sh == SHPFC_CH_STX
              || st_reg.rx_sh == SHPFC_CH_ETX) st_next.rx_ctl = 1'b1; // RULE3
          if (st_reg.rx_sh == SHPFC_CH_ACK
              || st_reg.rx_sh == SHPFC_CH_NAK) st_next.rx_ack = 1'b1; // RULE4
        end
      end
      default: st_next.rx_st = SHPFC_S_IDLE;
    endcase
    // transmitter, one stop bit, parity as selected
    if (st_reg.tx_st != SHPFC_S_IDLE)
      st_next.tx_cnt = tx_tick ? div - 13'h0001 : st_reg.tx_cnt - 13'h0001;
    unique case (st_reg.tx_st)
      SHPFC_S_IDLE: st_next.tx_line = 1'b1;
      SHPFC_S_START: begin
        st_next.tx_line = 1'b0; // RULE15
        if (tx_tick) begin
          st_next.tx_st  = SHPFC_S_DATA;
          st_next.tx_bit = 3'h0;
          st_next.tx_line = st_reg.tx_sh[0];
        end
      end
      SHPFC_S_DATA: if (tx_tick) begin
        st_next.tx_bit = st_reg.tx_bit + 3'h1;
        if (st_reg.tx_bit == 3'h7) begin
          st_next.tx_st   = par_on ? SHPFC_S_PAR : SHPFC_S_STOP;
          st_next.tx_line = par_on ? (^st_reg.tx_sh ^ par_odd) : 1'b1;
        end else st_next.tx_line = st_reg.tx_sh[st_reg.tx_bit + 3'h1];
      end
      SHPFC_S_PAR: if (tx_tick) begin
        st_next.tx_st   = SHPFC_S_STOP;
        st_next.tx_line = 1'b1;
      end
      SHPFC_S_STOP: if (tx_tick) st_next.tx_st = SHPFC_S_IDLE; // RULE2
      default: st_next.tx_st = SHPFC_S_IDLE;
    endcase
  end

  // the single state register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
      st_reg.s_rx    <= 2'h3;
      st_reg.s_cts   <= 2'h0;
      st_reg.ctrl    <= SHPFC_CTRL_RST;
      st_reg.nfull   <= SHPFC_NFULL_RST;
      st_reg.tx_line <= 1'b1;
      st_reg.rx_st   <= SHPFC_S_IDLE;
      st_reg.tx_st   <= SHPFC_S_IDLE;
    end else st_reg <= st_next;
  end

  // checks next to the logic
  property p_busy_offline;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      !online |-> !o_ready_busy;
  endproperty
  a_busy_offline: assert property (p_busy_offline) // RULE12
    else $error("ready/busy high while off-line");
  property p_busy_sjob;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (st_reg.ctrl[SHPFC_CTRL_SJOB_POS] && st_reg.ctrl[SHPFC_CTRL_PRT_POS])
      |-> !o_ready_busy;
  endproperty
  a_busy_sjob: assert property (p_busy_sjob) // RULE13
    else $error("ready/busy high during single-job print");
  property p_busy_full;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (f_count >= st_reg.nfull) |-> !o_ready_busy;
  endproperty
  a_busy_full: assert property (p_busy_full) // RULE14
    else $error("ready/busy high at near-full");
  property p_err_head;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(st_reg.s_head[1]) |-> !o_error_n ##1 !o_error_n;
  endproperty
  a_err_head: assert property (p_err_head) // RULE6
    else $error("error line high with head open");
  property p_err_release;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (st_reg.head_latch && !online) |=> !o_error_n;
  endproperty
  a_err_release: assert property (p_err_release) // RULE7
    else $error("error line released while off-line");
  property p_rx_gate;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (st_reg.rx_st == SHPFC_S_IDLE && !rx_ok)
      |=> st_reg.rx_st == SHPFC_S_IDLE;
  endproperty
  a_rx_gate: assert property (p_rx_gate) // RULE8
    else $error("reception started without cts and dsr");
  property p_tx_start;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (st_reg.tx_st == SHPFC_S_START && !tx_tick) |=> !o_tx_data;
  endproperty
  a_tx_start: assert property (p_tx_start) // RULE15
    else $error("start bit not low");
  property p_stop_err;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (st_reg.rx_st == SHPFC_S_STOP && bit_tick && !st_reg.s_rx[1])
      |=> st_reg.rx_err && !st_reg.push;
  endproperty
  a_stop_err: assert property (p_stop_err) // RULE16
    else $error("missing stop bit not flagged");
endmodule : shpfc_port

//--- shpfc_host_model.sv
// behavioural host serial port facing the printer's serial pins
`timescale 1ns/1ps
module shpfc_host_model (
  // clock
  input  wire logic i_sys_clk,
  // serial data
  output logic      o_host_tx,
  input  wire logic i_host_rx,
  // qualifiers driven by the host
  output logic      o_cts,
  output logic      o_dsr
);
  // line marks idle; qualifiers strapped high unless a test drops them
  initial begin
    o_host_tx = 1'b1;
    o_cts     = 1'b1;
    o_dsr     = 1'b1;
  end
  // drive both qualifiers at once, without waiting for a clock edge
  task automatic lines(input logic cts, input logic dsr);
    o_cts <= cts;
    o_dsr <= dsr;
  endtask : lines
  // one frame; par 0 none 1 odd 2 even; bad flips parity or drops stop
  task automatic send(input logic [7:0] c, input logic [1:0] par,
                      input logic bad, input int div);
    logic [10:0] f;
    int          n;
    f = {2'b11, c, 1'b0};
    n = 10;
    if (par != 2'h0) begin
      f[9] = ((par == 2'h1) ? ~^c : ^c) ^ bad;
      n    = 11;
    end else f[9] = !bad;
    for (int i = 0; i < n; i++) begin
      o_host_tx <= f[i];
      repeat (div) @(posedge i_sys_clk);
    end
    o_host_tx <= 1'b1; // line back to mark after a broken stop bit
  endtask : send
  // capture eleven bit slots mid-bit; a missing start shows as f[0] high
  task automatic grab(input int div, output logic [10:0] f);
    int k;
    k = 0;
    while (i_host_rx !== 1'b0 && k < 20000) begin
      @(posedge i_sys_clk);
      k++;
    end
    repeat (div / 2) @(posedge i_sys_clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = i_host_rx;
      repeat (div) @(posedge i_sys_clk);
    end
  endtask : grab
endmodule : shpfc_host_model

//--- tb_top.sv
// self-checking testbench for the serial host port
`timescale 1ns/1ps
module tb_top;
  import shpfc_pkg::*;
  localparam int DIV3 = SHPFC_CLK_HZ / SHPFC_BAUD3;
  logic        sys_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic        head_open = 1'b0;
  logic [1:0]  htrans    = 2'h0;
  logic [7:0]  haddr     = 8'h00;
  logic [31:0] hwdata    = 32'h0;
  logic        hready, hresp, tx_line, rx_line, cts, dsr;
  logic        error_n, ready_busy;
  logic [31:0] hrdata;
  logic [10:0] fr;
  logic [7:0]  ch;
  int          miscompares, total_checks, k, n;

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  shpfc_port #(.DEPTH(32)) dut_u (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_rx_data(rx_line), .o_tx_data(tx_line), .i_clear_to_send(cts),
    .i_data_set_ready(dsr), .o_error_n(error_n),
    .o_ready_busy(ready_busy), .i_head_open(head_open));
  shpfc_host_model host_u (
    .i_sys_clk(sys_clk), .o_host_tx(rx_line), .i_host_rx(tx_line),
    .o_cts(cts), .o_dsr(dsr));

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic pin(input string what, input logic exp, input logic got);
    check(what, {31'h0, exp}, {31'h0, got});
  endtask : pin
  // one edge, retried while the slave stalls; bounded
  task automatic edge_rdy();
    int j;
    j = 0;
    do begin
      @(posedge sys_clk);
      j++;
    end while (hready !== 1'b1 && j < 50);
    if (j >= 50) begin
      miscompares++;
      print_verdict();
    end
  endtask : edge_rdy
  // single ahb-lite transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(what, exp, r & m);
  endtask : rd_chk
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
  endtask : do_reset
  task automatic settle();
    repeat (4) @(posedge sys_clk);
  endtask : settle
  // cycles per bit from the line rate
  function automatic int bit_time(input int b);
    case (b)
      0: return SHPFC_CLK_HZ / SHPFC_BAUD0;
      1: return SHPFC_CLK_HZ / SHPFC_BAUD1;
      2: return SHPFC_CLK_HZ / SHPFC_BAUD2;
      default: return SHPFC_CLK_HZ / SHPFC_BAUD3;
    endcase
  endfunction : bit_time
  // start low, data lsb first, even parity, one stop
  function automatic logic [10:0] exp_frame(input logic [7:0] c);
    return {1'b1, ^c, c, 1'b0};
  endfunction : exp_frame

  initial begin
    void'($urandom(16544));
    do_reset();
    // reset values and an unmapped word
    rd_chk("ctrl", SHPFC_CTRL_OFF, 32'hFF, 32'h0);
    rd_chk("nearfull", SHPFC_NFULL_OFF, 32'h3F, 32'h1C);
    rd_chk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    pin("rdy offline", 1'b0, ready_busy);
    pin("hresp okay", 1'b0, hresp);
    pin("tx idle", 1'b1, tx_line);
    pin("err idle", 1'b1, error_n);
    // start-bit width at each rate; reset cuts every frame short
    for (int b = 0; b < 4; b++) begin
      wr(SHPFC_CTRL_OFF, 32'(b));
      wr(SHPFC_TXDATA_OFF, 32'h01);
      k = 0;
      n = 0;
      while (tx_line !== 1'b0 && k < 50) begin
        @(posedge sys_clk);
        k++;
      end
      while (tx_line === 1'b0 && n < 6000) begin
        @(posedge sys_clk);
        n++;
      end
      check("bit time", 32'(bit_time(b)), 32'(n));
      do_reset();
    end
    // random transmit frame, even parity
    ch = 8'($urandom);
    wr(SHPFC_CTRL_OFF, 32'h0B);
    fork
      host_u.grab(DIV3, fr);
      wr(SHPFC_TXDATA_OFF, {24'h0, ch});
    join
    check("tx frame", {21'h0, exp_frame(ch)}, {21'h0, fr});
    // head open latches the error line until back on-line
    head_open <= 1'b1;
    settle();
    pin("err head", 1'b0, error_n);
    head_open <= 1'b0;
    settle();
    pin("err latch", 1'b0, error_n);
    wr(SHPFC_CTRL_OFF, 32'h1B);
    settle();
    pin("err online", 1'b1, error_n);
    pin("rdy online", 1'b1, ready_busy);
    wr(SHPFC_CTRL_OFF, 32'h9B);
    settle();
    pin("err fault", 1'b0, error_n);
    wr(SHPFC_CTRL_OFF, 32'h7B);
    settle();
    pin("rdy printing", 1'b0, ready_busy);
    // near-full threshold of one character, parity off
    wr(SHPFC_NFULL_OFF, 32'h1);
    wr(SHPFC_CTRL_OFF, 32'h13);
    ch = 8'($urandom);
    host_u.send(ch, 2'h0, 1'b0, DIV3);
    settle();
    pin("rdy nearfull", 1'b0, ready_busy);
    rd_chk("count", SHPFC_STAT_OFF, 32'h3F0000, 32'h10000);
    rd_chk("rx char", SHPFC_RXDATA_OFF, 32'h1FF, {23'h1, ch});
    settle();
    pin("rdy drained", 1'b1, ready_busy);
    // delimiter with odd parity, acknowledge with even parity
    for (int i = 0; i < 2; i++) begin
      ch = i ? SHPFC_CH_ACK : SHPFC_CH_STX;
      wr(SHPFC_CTRL_OFF, i ? 32'h1B : 32'h17);
      host_u.send(ch, i ? 2'h2 : 2'h1, 1'b0, DIV3);
      settle();
      rd_chk("ctl flag", SHPFC_STAT_OFF, 32'h3000,
             i ? 32'h3000 : 32'h1000);
      rd_chk("ctl char", SHPFC_RXDATA_OFF, 32'h1FF, {23'h1, ch});
    end
    wr(SHPFC_STAT_OFF, 32'h800);
    rd_chk("ctl clear", SHPFC_STAT_OFF, 32'h3000, 32'h0);
    // one qualifier low at a time: nothing may be taken
    for (int i = 0; i < 2; i++) begin
      host_u.lines(i[0], !i[0]);
      settle();
      host_u.send(8'($urandom), 2'h2, 1'b0, DIV3);
      settle();
      rd_chk("refused", SHPFC_STAT_OFF, 32'h4, 32'h0);
    end
    host_u.lines(1'b1, 1'b1);
    settle();
    // parity mismatch sets the sticky receive error
    host_u.send(8'h55, 2'h2, 1'b1, DIV3);
    settle();
    rd_chk("rx err", SHPFC_STAT_OFF, 32'h100, 32'h100);
    wr(SHPFC_STAT_OFF, 32'h100);
    rd_chk("rx err clr", SHPFC_STAT_OFF, 32'h100, 32'h0);
    // missing stop bit: error flagged and the character dropped
    wr(SHPFC_CTRL_OFF, 32'h13);
    host_u.send(8'hA5, 2'h0, 1'b1, DIV3);
    settle();
    rd_chk("stop err", SHPFC_STAT_OFF, 32'h3F0100, 32'h10100);
    print_verdict();
  end
endmodule : tb_top
